// *** design/cal_seq_params.svh ***
// constants for the converter calibration sequencer
`ifndef CAL_SEQ_PARAMS_SVH
`define CAL_SEQ_PARAMS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_TRIG 4'h1
`define ADDR_LPCFG 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_TRIM0 4'h4
`define ADDR_TRIM1 4'h5
`define ADDR_TRIM2 4'h6
`define ADDR_TRIM3 4'h7
`define CTRL_CAL_EN 0
`define CTRL_BG_EN 1
`define CTRL_TRIG_SEL 2
`define CTRL_FG_OS 3
`define CTRL_BG_OS 4
`define CTRL_LOW_POWER_BG_ENABLE 5
`define CTRL_LP_SEL 6
`define CTRL_DUAL 7
`define CTRL_INSEL 8
`define CTRL_RESET 16'h0181
`define MIDCODE 8'h00
`define TRIM_FACTORY 8'h80
`define CAL_PASS_CYCLES 16'h0040
`define OS_PASS_CYCLES 16'h0080
`define SLEEP_UNIT 16'h0010
`define WAKE_UNIT 16'h0004
`define LPCFG_RESET 8'h44
`endif

// *** design/cal_seq_pkg.sv ***
// types for the converter calibration sequencer
package cal_seq_pkg;
	typedef enum logic [1:0] {core_a, core_b, core_c} core_id_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic [2:0] online;
		logic [2:0] powered;
		logic [2:0] calibrating;
	} core_status_t;
endpackage : cal_seq_pkg

// *** design/cal_down_counter.sv ***
// loadable down counter used to time calibration phases
`timescale 1ns/1ps
module cal_down_counter (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// control
	input wire logic load_i,
	input wire logic [15:0] value_i,
	// state
	output logic zero_o
);
	logic [15:0] count;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			// reset loads the first phase so it is already timing at release
			count <= value_i;
		end else if (load_i) begin
			count <= value_i;
		end else if (count != 16'h0000) begin
			count <= count - 16'h0001;
		end
	end
	// no load term here: callers feed zero_o straight back into load_i
	assign zero_o = (count == 16'h0000);
endmodule : cal_down_counter

// *** design/adc_calibration_sequencer.sv ***
// calibration sequencer for a three-core interleaved converter
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "cal_seq_params.svh"
module adc_calibration_sequencer (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// pins and converter side
	input wire logic cal_pin_trigger_i,
	input wire logic [7:0] offset_est_i,
	output logic [2:0] core_online_o,
	output logic [2:0] core_power_o,
	output logic [5:0] bank_cal_o,
	output logic [1:0] core_a_input_o,
	output logic [1:0] core_b_input_o,
	output logic midcode_out_o,
	output logic [7:0] midcode_value_o,
	output logic fg_cal_done_o
);
	typedef enum logic [3:0] {
		st_idle, st_fg_cal, st_fg_os, st_fg_end, st_bg_sleep, st_bg_wake,
		st_bg_cal, st_bg_os, st_bg_swap
	} state_t;

	cal_seq_pkg::reg_req_t req;
	cal_seq_pkg::core_status_t cores;
	state_t state;
	logic [15:0] ctrl;
	logic sw_cal_trigger;
	logic [7:0] lpcfg;
	logic [7:0] input_offset_trim [4];
	logic [7:0] next_trim;
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	logic soft_prev;
	logic trig_level;
	logic trig_edge;
	logic fg_cal_done;
	logic bg_run;
	cal_seq_pkg::core_id_t spare;
	cal_seq_pkg::core_id_t victim;
	logic cnt_load;
	logic [15:0] cnt_value;
	logic cnt_zero;
	logic [1:0] trim_sel;
	cal_seq_pkg::core_id_t next_victim;
	logic [1:0] next_a_input;
	logic [1:0] next_b_input;
	logic fg_phase;
	logic trim_core_b;
	logic trim_input_b;

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	// control bits
	wire cal_en = ctrl[`CTRL_CAL_EN];
	wire background_cal_enable = ctrl[`CTRL_BG_EN];
	wire trigger_source_select = ctrl[`CTRL_TRIG_SEL];
	wire fg_offset_cal_enable = ctrl[`CTRL_FG_OS];
	wire bg_offset_cal_enable = ctrl[`CTRL_BG_OS];
	wire low_power_bg_enable = ctrl[`CTRL_LOW_POWER_BG_ENABLE];
	wire low_power_switch_select = ctrl[`CTRL_LP_SEL];
	wire dual_channel = ctrl[`CTRL_DUAL];
	wire [3:0] spare_sleep_delay = lpcfg[3:0];
	wire [3:0] spare_wake_delay = lpcfg[7:4];
	wire offset_cal_active = (fg_offset_cal_enable && state == st_fg_os) || bg_offset_cal_enable;

	// pin synchroniser; first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
			soft_prev <= 1'b0;
		end else begin
			pin_meta <= cal_pin_trigger_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			soft_prev <= sw_cal_trigger;
		end
	end

	// select bit high picks the pin, low picks the software bit
	assign trig_level = trigger_source_select ? pin_sync : sw_cal_trigger;
	assign trig_edge = trigger_source_select ? (pin_sync && !pin_prev)
		: (sw_cal_trigger && !soft_prev);

	// host-written registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl <= `CTRL_RESET;
			sw_cal_trigger <= 1'b0;
			lpcfg <= `LPCFG_RESET;
		end else if (req.wr) begin
			case (req.addr)
				`ADDR_CTRL: ctrl <= req.wdata;
				`ADDR_TRIG: sw_cal_trigger <= req.wdata[0];
				`ADDR_LPCFG: lpcfg <= req.wdata[7:0];
				default: ;
			endcase
		end
	end

	// offset trims: factory value at reset, host may adjust, calibration overwrites
	// trim index: high bit core B, low bit input B
	always_comb begin
		trim_core_b = 1'b0;
		trim_input_b = 1'b0;
		case (state)
			st_fg_os: begin
				// single channel: core B carries the trim; dual: first input on core A
				trim_core_b = !dual_channel;
				trim_input_b = 1'b0;
			end
			st_bg_os: begin
				trim_core_b = (victim == cal_seq_pkg::core_b);
				trim_input_b = dual_channel && (victim == cal_seq_pkg::core_b);
			end
			default: ;
		endcase
	end
	assign trim_sel = {trim_core_b, trim_input_b};
	assign next_trim = offset_est_i;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 4; i++) begin
				input_offset_trim[i] <= `TRIM_FACTORY;
			end
		end else if ((state == st_fg_os || state == st_bg_os) && cnt_zero) begin
			input_offset_trim[trim_sel] <= next_trim;
		end else if (req.wr && req.addr[3:2] == 2'b01 && !offset_cal_active) begin
			input_offset_trim[req.addr[1:0]] <= req.wdata[7:0];
		end
	end

	// sequencer
	cal_down_counter phase_timer (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.load_i(cnt_load),
		.value_i(cnt_value),
		.zero_o(cnt_zero)
	);

	always_comb begin
		cnt_load = 1'b0;
		cnt_value = `CAL_PASS_CYCLES;
		case (state)
			st_idle: begin
				cnt_load = 1'b1;
				cnt_value = (bg_run && low_power_bg_enable) ? 16'(spare_sleep_delay) * `SLEEP_UNIT
					: `CAL_PASS_CYCLES;
			end
			st_fg_cal, st_bg_cal: begin
				cnt_load = cnt_zero;
				cnt_value = `OS_PASS_CYCLES;
			end
			st_bg_sleep: begin
				// paced mode holds the count at zero so a late trigger is not missed
				cnt_load = cnt_zero && (!low_power_switch_select || trig_edge);
				cnt_value = 16'(spare_wake_delay) * `WAKE_UNIT;
			end
			st_bg_wake: begin
				cnt_load = cnt_zero;
				cnt_value = `CAL_PASS_CYCLES;
			end
			default: ;
		endcase
		// the power-up pass needs a full count the moment reset lets go
		if (reset_i) begin
			cnt_value = `CAL_PASS_CYCLES;
		end
	end

	assign bg_run = background_cal_enable && !trigger_source_select && sw_cal_trigger;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= st_fg_cal;
		end else begin
			case (state)
				st_idle: begin
					if (bg_run && cal_en) begin
						state <= low_power_bg_enable ? st_bg_sleep : st_bg_cal;
					end else if (trig_edge && cal_en) begin
						state <= st_fg_cal;
					end
				end
				st_fg_cal: if (cnt_zero) state <= fg_offset_cal_enable ? st_fg_os : st_fg_end;
				st_fg_os: if (cnt_zero) state <= st_fg_end;
				st_fg_end: state <= st_idle;
				st_bg_sleep: begin
					// user-paced mode waits for the trigger once sleep is over
					if (cnt_zero && (!low_power_switch_select || trig_edge)) state <= st_bg_wake;
				end
				st_bg_wake: if (cnt_zero) state <= st_bg_cal;
				st_bg_cal: if (cnt_zero) state <= bg_offset_cal_enable ? st_bg_os : st_bg_swap;
				st_bg_os: if (cnt_zero) state <= st_bg_swap;
				st_bg_swap: state <= st_idle;
				default: state <= st_idle;
			endcase
		end
	end

	// next victim is the online core that is neither old spare nor old victim,
	// so every core, C included, gets its turn
	always_comb begin
		if (spare != cal_seq_pkg::core_a && victim != cal_seq_pkg::core_a) begin
			next_victim = cal_seq_pkg::core_a;
		end else if (spare != cal_seq_pkg::core_b && victim != cal_seq_pkg::core_b) begin
			next_victim = cal_seq_pkg::core_b;
		end else begin
			next_victim = cal_seq_pkg::core_c;
		end
	end

	// spare rotation: spare replaces victim, released victim becomes spare
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			spare <= cal_seq_pkg::core_c;
			victim <= cal_seq_pkg::core_a;
		end else if (state == st_bg_swap) begin
			spare <= victim;
			victim <= next_victim;
		end else if (!bg_run && state == st_idle) begin
			spare <= cal_seq_pkg::core_c;
			victim <= cal_seq_pkg::core_a;
		end
	end

	// core status derived from phase
	always_comb begin
		cores.online = 3'b111;
		cores.online[spare] = 1'b0;
		cores.powered = 3'b111;
		cores.calibrating = 3'b000;
		case (state)
			st_fg_cal, st_fg_os, st_fg_end: begin
				cores.online = 3'b000;
				cores.calibrating = 3'b011;
			end
			st_bg_sleep: cores.powered[spare] = 1'b0;
			st_bg_cal, st_bg_os: cores.calibrating[spare] = 1'b1;
			st_idle: if (bg_run && low_power_bg_enable) cores.powered[spare] = 1'b0;
			default: ;
		endcase
	end

	assign fg_phase = (state == st_fg_cal || state == st_fg_os || state == st_fg_end);

	// dual channel: A on first input, B on second; single: both on the selected input
	always_comb begin
		if (dual_channel) begin
			next_a_input = 2'b01;
			next_b_input = 2'b10;
		end else if (ctrl[`CTRL_INSEL]) begin
			next_a_input = 2'b10;
			next_b_input = 2'b10;
		end else begin
			next_a_input = 2'b01;
			next_b_input = 2'b01;
		end
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			core_online_o <= 3'b000;
			core_power_o <= 3'b111;
			bank_cal_o <= 6'h00;
			midcode_out_o <= 1'b1;
			midcode_value_o <= `MIDCODE;
			core_a_input_o <= 2'b01;
			core_b_input_o <= 2'b10;
		end else begin
			core_online_o <= cores.online;
			core_power_o <= cores.powered;
			// each core's two banks calibrate together against the reference
			bank_cal_o <= {{2{cores.calibrating[2]}}, {2{cores.calibrating[1]}},
				{2{cores.calibrating[0]}}};
			midcode_out_o <= fg_phase;
			midcode_value_o <= `MIDCODE;
			core_a_input_o <= next_a_input;
			core_b_input_o <= next_b_input;
		end
	end

	// done flag
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			fg_cal_done <= 1'b0;
		end else if (state == st_fg_end) begin
			fg_cal_done <= 1'b1;
		end else if (state == st_idle && trig_edge && cal_en && !bg_run) begin
			fg_cal_done <= 1'b0;
		end
	end
	assign fg_cal_done_o = fg_cal_done;

	// read port
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= 16'h0000;
		end else if (req.rd) begin
			case (req.addr)
				`ADDR_CTRL: rdata_o <= ctrl;
				`ADDR_TRIG: rdata_o <= {15'h0000, sw_cal_trigger};
				`ADDR_LPCFG: rdata_o <= {8'h00, lpcfg};
				`ADDR_STATUS: rdata_o <= {4'h0, state, 1'b0, trig_level, spare, cores.online, fg_cal_done};
				`ADDR_TRIM0, `ADDR_TRIM1, `ADDR_TRIM2, `ADDR_TRIM3:
					rdata_o <= {8'h00, input_offset_trim[req.addr[1:0]]};
				default: rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end
endmodule : adc_calibration_sequencer

// *** verification/cal_seq_props.sv ***
// checker for the calibration sequencer outputs
`timescale 1ns/1ps
module cal_seq_props (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic [2:0] core_online_o,
	input wire logic [2:0] core_power_o,
	input wire logic [5:0] bank_cal_o,
	input wire logic [1:0] core_a_input_o,
	input wire logic [1:0] core_b_input_o,
	input wire logic midcode_out_o,
	input wire logic [7:0] midcode_value_o,
	input wire logic fg_cal_done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic [2:0] in_cal;
	assign in_cal = {|bank_cal_o[5:4], |bank_cal_o[3:2], |bank_cal_o[1:0]};
	a_midcode_zero: assert property (midcode_out_o |-> midcode_value_o == 8'h00)
		else $error("midcode value wrong");
	a_offline_midcode: assert property (midcode_out_o && !fg_cal_done_o |-> core_online_o == 3'b000)
		else $error("core online in foreground pass");
	a_start_midcode: assert property ($fell(fg_cal_done_o) |=> midcode_out_o)
		else $error("midcode late after start");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data outside slot");
	a_input_onehot: assert property ($onehot(core_a_input_o) && $onehot(core_b_input_o))
		else $error("input select not one-hot");
	a_bank_pairs: assert property (bank_cal_o[0] == bank_cal_o[1] && bank_cal_o[2] == bank_cal_o[3]
		&& bank_cal_o[4] == bank_cal_o[5])
		else $error("banks of a core split");
	a_cal_offline: assert property ((core_online_o & in_cal) == 3'b000)
		else $error("core online while calibrating");
	a_cal_powered: assert property ((in_cal & ~core_power_o) == 3'b000)
		else $error("calibrating unpowered core");
	c_fg_cal_done: cover property ($rose(fg_cal_done_o));
	c_spare_cal: cover property (bank_cal_o[5:4] == 2'b11);
	c_spare_on: cover property (core_online_o[2]);
endmodule : cal_seq_props
bind adc_calibration_sequencer cal_seq_props cal_seq_props_i (.clk_i, .reset_i, .rd_i, .rdata_o,
	.core_online_o, .core_power_o, .bank_cal_o, .core_a_input_o, .core_b_input_o,
	.midcode_out_o, .midcode_value_o, .fg_cal_done_o);

// *** verification/cal_host_model.sv ***
// host side model: trigger pin and offset estimate
`timescale 1ns/1ps
module cal_host_model (
	input wire logic clk_i,
	output logic pin_o,
	output logic [7:0] est_o
);
	initial begin
		pin_o = 1'b0;
		est_o = 8'h5a;
	end
	// held several clocks so the two-stage sync sees it
	task fire();
		@(posedge clk_i);
		pin_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		pin_o <= 1'b0;
	endtask : fire
endmodule : cal_host_model

// *** verification/adc_calibration_sequencer_bench.sv ***
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
`include "cal_seq_params.svh"
module adc_calibration_sequencer_bench;
	logic clk_i, reset_i, wr_i, rd_i, cal_pin_trigger_i, midcode_out_o, fg_cal_done_o;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o, rd_data;
	logic [7:0] offset_est_i, midcode_value_o;
	logic [2:0] core_online_o, core_power_o;
	logic [5:0] bank_cal_o;
	logic [1:0] core_a_input_o, core_b_input_o;
	int miscompares = 0;
	int tests_run = 0;
	int n;
	logic [19:0] rows [7] = '{{`ADDR_CTRL, `CTRL_RESET}, {`ADDR_LPCFG, 8'h00, `LPCFG_RESET},
		{`ADDR_TRIM0, 8'h00, `TRIM_FACTORY}, {`ADDR_TRIM1, 8'h00, `TRIM_FACTORY},
		{`ADDR_TRIM2, 8'h00, `TRIM_FACTORY}, {`ADDR_TRIM3, 8'h00, `TRIM_FACTORY}, {4'h9, 16'h0000}};
	adc_calibration_sequencer adc_calibration_sequencer_i (.clk_i, .reset_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .cal_pin_trigger_i, .offset_est_i, .core_online_o, .core_power_o,
		.bank_cal_o, .core_a_input_o, .core_b_input_o, .midcode_out_o, .midcode_value_o, .fg_cal_done_o);
	cal_host_model cal_host_model_i (.clk_i, .pin_o(cal_pin_trigger_i), .est_o(offset_est_i));
	task chk(input string s, input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rd_data = rdata_o;
	endtask : rd
	task wait_done(input logic v, input int lim);
		n = 0;
		while (fg_cal_done_o !== v && n < lim) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask : wait_done
	task end_of_test();
		if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		#2000000;
		miscompares++;
		end_of_test();
	end
	initial begin
		{reset_i, wr_i, rd_i, addr_i, wdata_i} = {3'b100, 20'h00000};
		repeat (12) @(posedge clk_i);
		#1 chk("power", core_power_o, 3'b111);
		chk("midcode", midcode_out_o, 1'b1);
		chk("done", fg_cal_done_o, 1'b0);
		@(posedge clk_i);
		reset_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		#1 chk("early", fg_cal_done_o, 1'b0);
		chk("offline", core_online_o, 3'b000);
		wait_done(1'b1, 100);
		chk("pwrup", fg_cal_done_o, 1'b1);
		repeat (3) @(posedge clk_i);
		#1 chk("online", core_online_o[1:0], 2'b11);
		chk("a in", core_a_input_o, 2'b01);
		chk("b in", core_b_input_o, 2'b10);
		for (int i = 0; i < 7; i++) begin
			rd(rows[i][19:16]);
			chk("reg", rd_data, rows[i][15:0]);
		end
		for (int s = 0; s < 2; s++) begin
			wr(`ADDR_CTRL, {7'h00, s[0], 8'h01});
			repeat (2) @(posedge clk_i);
			#1 chk("single a", core_a_input_o, 2'b01 << s);
			chk("single b", core_b_input_o, 2'b01 << s);
		end
		wr(`ADDR_TRIM1, 16'h0033);
		rd(`ADDR_TRIM1);
		chk("trim wr", rd_data, 16'h0033);
		wr(`ADDR_CTRL, 16'h0088);
		wr(`ADDR_CTRL, 16'h0089);
		wr(`ADDR_TRIG, 16'h0001);
		repeat (3) @(posedge clk_i);
		#1 chk("start", fg_cal_done_o, 1'b0);
		chk("midcode", midcode_out_o, 1'b1);
		repeat (150) @(posedge clk_i);
		#1 chk("os long", fg_cal_done_o, 1'b0);
		wait_done(1'b1, 100);
		chk("os done", fg_cal_done_o, 1'b1);
		rd(`ADDR_TRIM0);
		chk("os trim", rd_data, 16'h005a);
		wr(`ADDR_TRIG, 16'h0000);
		wr(`ADDR_CTRL, 16'h0085);
		wr(`ADDR_TRIG, 16'h0001);
		repeat (5) @(posedge clk_i);
		#1 chk("sw ignored", fg_cal_done_o, 1'b1);
		cal_host_model_i.fire();
		wait_done(1'b0, 10);
		chk("pin start", fg_cal_done_o, 1'b0);
		wait_done(1'b1, 100);
		chk("pin done", fg_cal_done_o, 1'b1);
		wr(`ADDR_CTRL, 16'h0093);
		wr(`ADDR_TRIG, 16'h0001);
		n = 0;
		while (core_online_o[2] !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk("spare on", core_online_o[2], 1'b1);
		chk("no gap", midcode_out_o, 1'b0);
		wr(`ADDR_TRIM1, 16'h0011);
		rd(`ADDR_TRIM1);
		chk("trim lock", rd_data, 16'h0033);
		wr(`ADDR_CTRL, 16'h00a3);
		n = 0;
		while (core_power_o === 3'b111 && n < 3000) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk("lp sleep", core_power_o == 3'b111, 1'b0);
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk("rst online", core_online_o, 3'b000);
		chk("rst power", core_power_o, 3'b111);
		chk("rst done", fg_cal_done_o, 1'b0);
		@(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk("rst midcode", midcode_out_o, 1'b1);
		chk("rst offline", core_online_o, 3'b000);
		wait_done(1'b1, 100);
		chk("rst pwrup", fg_cal_done_o, 1'b1);
		end_of_test();
	end
endmodule : adc_calibration_sequencer_bench
